/* File: core/gzb_pkg.sv */
// Purpose: Shared constants and types for the general-purpose port block.
// Assumes: Eight-bit register bus with byte-wide data in the low lane.
// Notes:   Every offset, field position and reset value is named here once.
`default_nettype none
package gzb_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] GZB_OFF_PORT_A_DATA = 8'h00; // Port A latch write, port read.
  localparam logic [7:0] GZB_OFF_PORT_B_DATA = 8'h04; // Port B latch write, port read.
  localparam logic [7:0] GZB_OFF_PORT_C_DATA = 8'h08; // Port C latch write, port read.
  localparam logic [7:0] GZB_OFF_PORT_A_DIR  = 8'h0C; // port_a_direction.
  localparam logic [7:0] GZB_OFF_PORT_B_DIR  = 8'h10; // port_b_direction.
  localparam logic [7:0] GZB_OFF_PORT_C_FSEL = 8'h14; // port_c_function_select.
  localparam logic [7:0] GZB_OFF_PORT_C_DIR  = 8'h18; // port_c_direction.
  localparam logic [7:0] GZB_OFF_ZERO_CROSS  = 8'h1C; // zero_cross_control.
  localparam logic [7:0] GZB_OFF_BIT_OP      = 8'h20; // Single-bit set, clear and test.

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] GZB_DIR_RST   = 8'hFF; // All pins are inputs.
  localparam logic [7:0] GZB_FSEL_RST  = 8'h00; // All port C pins in port mode.
  localparam logic [7:0] GZB_ZCM_RST   = 8'h06; // Both bias bits set.
  localparam logic [7:0] GZB_LATCH_RST = 8'h00; // Latch content is not promised.

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned GZB_ZC1_BIT    = 1; // irq1_zero_cross_bias.
  localparam int unsigned GZB_ZC2_BIT    = 2; // irq2_zero_cross_bias.
  localparam int unsigned GZB_PC3_BIT    = 3; // port_c_bit3, irq2_or_timer_input.
  localparam logic [7:0]  GZB_ZCM_MASK   = 8'h06; // Writable bias bits.
  localparam logic [7:0]  GZB_CTL_OUTCAP = 8'hD5; // Control roles that can drive.
  localparam int unsigned GZB_OP_LSB     = 6; // Bit operation code, two bits.
  localparam int unsigned GZB_SEL_LSB    = 4; // Port selector, two bits.
  localparam int unsigned GZB_IDX_LSB    = 0; // Bit index, three bits.

  // Operation codes of the single-bit register.
  typedef enum logic [1:0] {
    GZB_OP_NONE  = 2'b00,
    GZB_OP_SET   = 2'b01,
    GZB_OP_CLEAR = 2'b10,
    GZB_OP_TEST  = 2'b11
  } gzb_bitop_t;

endpackage
`default_nettype wire

/* File: core/gzb_sync3.sv */
// Purpose: Three-stage synchroniser for a group of pin inputs.
// Assumes: Inputs are asynchronous to ref_clk.
// Notes:   A change is accepted once the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none
module gzb_sync3 (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // Pins
  input  wire logic [7:0] async_in,
  // Settled level
  output logic      [7:0] level_out
);

  // ****************************************************************
  // Stages
  // ****************************************************************
  logic [7:0] s1_reg;    // First stage, read only by the second.
  logic [7:0] s2_reg;    // Second stage.
  logic [7:0] s3_reg;    // Third stage.
  logic [7:0] lvl_reg;   // Accepted level.
  logic [7:0] lvl_next;  // Next accepted level.

  // Each bit settles on its own once its two late stages match.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
    end
  end

  // Plain shift through the stages.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg  <= 8'h00;
      s2_reg  <= 8'h00;
      s3_reg  <= 8'h00;
      lvl_reg <= 8'h00;
    end else begin
      s1_reg  <= async_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign level_out = lvl_reg;

endmodule
`default_nettype wire

/* File: core/gzb_ports.sv */
// Purpose: Three eight-bit parallel ports with zero-cross bias control.
// Assumes: Plain register port; hardware STOP arrives as a same-clock level.
// Notes:   Pin levels pass a three-stage synchroniser before any read.
`timescale 1ns/100ps
`default_nettype none
module gzb_ports
  import gzb_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Standby control
  input  wire logic       hw_stop,
  // Port A pins
  input  wire logic [7:0] port_a_pins_in,
  output logic      [7:0] port_a_pins_out,
  output logic      [7:0] port_a_pins_oe,
  // Port B pins
  input  wire logic [7:0] port_b_pins_in,
  output logic      [7:0] port_b_pins_out,
  output logic      [7:0] port_b_pins_oe,
  // Port C pins
  input  wire logic [7:0] port_c_pins_in,
  output logic      [7:0] port_c_pins_out,
  output logic      [7:0] port_c_pins_oe,
  // Peripheral side of port C
  input  wire logic [7:0] ctl_out,
  input  wire logic [7:0] ctl_oe,
  output logic      [7:0] ctl_in,
  // Zero-cross bias enables
  output logic            irq1_bias_en,
  output logic            irq2_bias_en
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] pa_sync;            // Settled port A pin levels.
  logic [7:0] pb_sync;            // Settled port B pin levels.
  logic [7:0] pc_sync;            // Settled port C pin levels.
  logic [7:0] lat_a_reg;          // Port A output latch.
  logic [7:0] lat_b_reg;          // Port B output latch.
  logic [7:0] lat_c_reg;          // Port C output latch.
  logic [7:0] lat_a_next;         // Next port A latch.
  logic [7:0] lat_b_next;         // Next port B latch.
  logic [7:0] lat_c_next;         // Next port C latch.
  logic [7:0] dir_a_reg;          // port_a_direction.
  logic [7:0] dir_b_reg;          // port_b_direction.
  logic [7:0] dir_c_reg;          // port_c_direction.
  logic [7:0] fsel_reg;           // port_c_function_select.
  logic [7:0] zcm_reg;            // zero_cross_control.
  logic [7:0] dir_a_next;         // Next port A direction.
  logic [7:0] dir_b_next;         // Next port B direction.
  logic [7:0] dir_c_next;         // Next port C direction.
  logic [7:0] fsel_next;          // Next function select.
  logic [7:0] zcm_next;           // Next bias control.
  logic       test_reg;           // Result of the last bit test.
  logic       test_next;          // Next bit test result.
  logic [7:0] rdata_reg;          // Registered read data.
  logic [7:0] rdata_next;         // Read data for the next cycle.
  logic [7:0] view_a;             // Port A as software sees it.
  logic [7:0] view_b;             // Port B as software sees it.
  logic [7:0] view_c;             // Port C as software sees it.
  logic [7:0] ctl_drive;          // Port C bits a peripheral drives.
  logic [7:0] view_sel;           // Port picked by a bit operation.
  logic [7:0] bit_mask;           // One-hot mask of a bit operation.
  logic [7:0] rmw_value;          // Full byte written back by a bit operation.
  gzb_bitop_t op;                 // Decoded operation code.
  logic [1:0] op_port;            // Port selector of a bit operation.
  logic       op_wr;              // A write to the bit operation register.

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Pins are sampled continuously; nothing is held for later reads.
  gzb_sync3 u_sync_a (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .async_in  (port_a_pins_in),
    .level_out (pa_sync)
  );

  gzb_sync3 u_sync_b (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .async_in  (port_b_pins_in),
    .level_out (pb_sync)
  );

  gzb_sync3 u_sync_c (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .async_in  (port_c_pins_in),
    .level_out (pc_sync)
  );

  // ****************************************************************
  // Port views and pin drive
  // ****************************************************************
  // A control role drives only where the role is an output and the
  // peripheral asks to drive, which lets the serial clock turn round.
  assign ctl_drive = fsel_reg & GZB_CTL_OUTCAP & ctl_oe;

  // Each bit picks pin, latch or control signal in one generate loop.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      // Inputs show the live pin, outputs the latch.
      assign view_a[gi] = dir_a_reg[gi] ? pa_sync[gi] : lat_a_reg[gi];
      assign view_b[gi] = dir_b_reg[gi] ? pb_sync[gi] : lat_b_reg[gi];
      // Control mode shows the control signal where it drives, else the pin; port mode as port A.
      assign view_c[gi] = fsel_reg[gi]
                        ? (ctl_drive[gi] ? ctl_out[gi] : pc_sync[gi])
                        : (dir_c_reg[gi] ? pc_sync[gi] : lat_c_reg[gi]);
      // Output enables: the latch is hidden while the bit is an input.
      assign port_a_pins_oe[gi] = ~dir_a_reg[gi];
      assign port_b_pins_oe[gi] = ~dir_b_reg[gi];
      // The control role overrides the direction bit.
      assign port_c_pins_oe[gi] = fsel_reg[gi] ? ctl_drive[gi] : ~dir_c_reg[gi];
      assign port_c_pins_out[gi] = fsel_reg[gi] ? ctl_out[gi] : lat_c_reg[gi];
    end
  endgenerate

  // Port A and B latches always face the pins; the enable decides what is seen.
  assign port_a_pins_out = lat_a_reg;
  assign port_b_pins_out = lat_b_reg;
  // Peripherals always see the settled pin levels.
  assign ctl_in = pc_sync;

  // ****************************************************************
  // Zero-cross bias
  // ****************************************************************
  // STOP gates both amplifiers; bit3 in port mode also gates pin two.
  // The analog amplifier itself lies outside this block.
  assign irq1_bias_en = zcm_reg[GZB_ZC1_BIT] & ~hw_stop;
  assign irq2_bias_en = zcm_reg[GZB_ZC2_BIT] & fsel_reg[GZB_PC3_BIT] & ~hw_stop;

  // ****************************************************************
  // Bit operation decode
  // ****************************************************************
  // A set or clear reads the whole port view, changes one bit and
  // writes the whole byte back, so input bits take the pin level.
  always_comb begin
    op_wr    = reg_wr && (reg_addr == GZB_OFF_BIT_OP);
    op       = gzb_bitop_t'(reg_wdata[GZB_OP_LSB +: 2]);
    op_port  = reg_wdata[GZB_SEL_LSB +: 2];
    bit_mask = 8'h01 << reg_wdata[GZB_IDX_LSB +: 3];
    case (op_port)
      2'b00:   view_sel = view_a;
      2'b01:   view_sel = view_b;
      2'b10:   view_sel = view_c;
      default: view_sel = 8'h00;
    endcase
    case (op)
      GZB_OP_SET:   rmw_value = view_sel | bit_mask;
      GZB_OP_CLEAR: rmw_value = view_sel & ~bit_mask;
      default:      rmw_value = view_sel;
    endcase
  end

  // ****************************************************************
  // Output latches
  // ****************************************************************
  // A byte write loads all eight bits whatever the direction says.
  always_comb begin
    lat_a_next = lat_a_reg;
    lat_b_next = lat_b_reg;
    lat_c_next = lat_c_reg;
    if (reg_wr) begin
      case (reg_addr)
        GZB_OFF_PORT_A_DATA: lat_a_next = reg_wdata;
        GZB_OFF_PORT_B_DATA: lat_b_next = reg_wdata;
        GZB_OFF_PORT_C_DATA: lat_c_next = reg_wdata;
        default: begin
        end
      endcase
    end
    // Only set and clear write back; a test leaves the latch alone.
    if (op_wr && (op == GZB_OP_SET || op == GZB_OP_CLEAR)) begin
      case (op_port)
        2'b00:   lat_a_next = rmw_value;
        2'b01:   lat_b_next = rmw_value;
        2'b10:   lat_c_next = rmw_value;
        default: begin
        end
      endcase
    end
  end

  // Latches are kept through STOP; only modes return to defaults.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lat_a_reg <= GZB_LATCH_RST;
      lat_b_reg <= GZB_LATCH_RST;
      lat_c_reg <= GZB_LATCH_RST;
    end else begin
      lat_a_reg <= lat_a_next;
      lat_b_reg <= lat_b_next;
      lat_c_reg <= lat_c_next;
    end
  end

  // ****************************************************************
  // Mode registers
  // ****************************************************************
  // STOP holds the directions and function select at their defaults, and writes
  // to them are ignored meanwhile, which keeps all pins quiet in standby.
  always_comb begin
    dir_a_next = dir_a_reg;
    dir_b_next = dir_b_reg;
    dir_c_next = dir_c_reg;
    fsel_next  = fsel_reg;
    zcm_next   = zcm_reg;
    if (reg_wr) begin
      case (reg_addr)
        GZB_OFF_PORT_A_DIR:  dir_a_next = reg_wdata;
        GZB_OFF_PORT_B_DIR:  dir_b_next = reg_wdata;
        GZB_OFF_PORT_C_DIR:  dir_c_next = reg_wdata;
        GZB_OFF_PORT_C_FSEL: fsel_next  = reg_wdata;
        GZB_OFF_ZERO_CROSS:  zcm_next   = reg_wdata & GZB_ZCM_MASK;
        default: begin
        end
      endcase
    end
    if (hw_stop) begin
      dir_a_next = GZB_DIR_RST;
      dir_b_next = GZB_DIR_RST;
      dir_c_next = GZB_DIR_RST;
      fsel_next  = GZB_FSEL_RST;
    end
  end

  // Reset puts every mode and both bias bits at their defaults.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_a_reg <= GZB_DIR_RST;
      dir_b_reg <= GZB_DIR_RST;
      dir_c_reg <= GZB_DIR_RST;
      fsel_reg  <= GZB_FSEL_RST;
      zcm_reg   <= GZB_ZCM_RST;
    end else begin
      dir_a_reg <= dir_a_next;
      dir_b_reg <= dir_b_next;
      dir_c_reg <= dir_c_next;
      fsel_reg  <= fsel_next;
      zcm_reg   <= zcm_next;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Read data appear in the cycle after the strobe and only there.
  // A bit test keeps its result for the next read of that register.
  always_comb begin
    test_next  = test_reg;
    rdata_next = 8'h00;
    if (op_wr && op == GZB_OP_TEST) begin
      test_next = |(view_sel & bit_mask);
    end
    if (reg_rd) begin
      case (reg_addr)
        GZB_OFF_PORT_A_DATA: rdata_next = view_a;
        GZB_OFF_PORT_B_DATA: rdata_next = view_b;
        GZB_OFF_PORT_C_DATA: rdata_next = view_c;
        GZB_OFF_PORT_A_DIR:  rdata_next = dir_a_reg;
        GZB_OFF_PORT_B_DIR:  rdata_next = dir_b_reg;
        GZB_OFF_PORT_C_DIR:  rdata_next = dir_c_reg;
        GZB_OFF_PORT_C_FSEL: rdata_next = fsel_reg;
        GZB_OFF_ZERO_CROSS:  rdata_next = zcm_reg;
        GZB_OFF_BIT_OP:      rdata_next = {7'h00, test_reg};
        default:             rdata_next = 8'h00;
      endcase
    end
  end

  // Registered read data and test result.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
      test_reg  <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      test_reg  <= test_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // A byte write to the port A data register.
  sequence s_write_a;
    reg_wr && reg_addr == GZB_OFF_PORT_A_DATA;
  endsequence

  // STOP held for two cycles.
  sequence s_stop_held;
    hw_stop [*2];
  endsequence

  a_bias_one_off: assert property (
    !zcm_reg[GZB_ZC1_BIT] |-> !irq1_bias_en)
    else $error("Bias one on while its bit is clear.");

  a_bias_one_on: assert property (
    zcm_reg[GZB_ZC1_BIT] && !hw_stop |-> irq1_bias_en)
    else $error("Bias one off while enabled.");

  a_bias_reset_set: assert property (
    $rose(reset_n) |-> zcm_reg == GZB_ZCM_RST)
    else $error("Bias bits not set after reset.");

  a_bias_two_port: assert property (
    !fsel_reg[GZB_PC3_BIT] |-> !irq2_bias_en)
    else $error("Bias two on with bit three in port mode.");

  a_stop_modes: assert property (
    s_stop_held |-> !irq1_bias_en && !irq2_bias_en && dir_a_reg == GZB_DIR_RST
      && dir_b_reg == GZB_DIR_RST && dir_c_reg == GZB_DIR_RST && fsel_reg == 8'h00)
    else $error("Modes not at defaults during STOP.");

  a_write_latch_a: assert property (
    s_write_a |=> lat_a_reg == $past(reg_wdata))
    else $error("Port A latch missed a byte write.");

  a_pin_drive_a: assert property (
    port_a_pins_oe == ~dir_a_reg && port_a_pins_out == lat_a_reg)
    else $error("Port A drive does not follow direction.");

  a_read_delay: assert property (
    reg_rd && reg_addr == GZB_OFF_PORT_A_DATA |=> reg_rdata == $past(view_a))
    else $error("Port A read data wrong or late.");

  // A control bit drives only where its role may drive and the peripheral
  // asks for it, whatever the direction bit underneath says.
  a_ctl_override: assert property (
    fsel_reg != 8'h00 |-> (port_c_pins_oe & fsel_reg & ~(GZB_CTL_OUTCAP & ctl_oe)) == 8'h00)
    else $error("Port C pin driven against its control role.");

  a_read_idle_zero: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("Read data stand outside the answer cycle.");

endmodule
`default_nettype wire

/* File: sim/gzb_pin_model.sv */
// Purpose: Board wiring on the far side of one eight-bit port.
// Assumes: An undriven pin follows the level the board puts on it.
// Notes:   The resolved level is fed back to the block's pin input.
`timescale 1ns/100ps
`default_nettype none
module gzb_pin_model (
  // Block side
  input  wire logic [7:0] pins_out,
  input  wire logic [7:0] pins_oe,
  // Board side
  input  wire logic [7:0] board_lvl,
  // Resolved wire
  output logic      [7:0] pins_in
);
  // A pin shows the block's level while driven, else the board's level.
  always_comb begin
    pins_in = (pins_out & pins_oe) | (board_lvl & ~pins_oe);
  end
endmodule
`default_nettype wire

/* File: sim/gzb_ports_tb.sv */
// Purpose: Self-checking bench for the three-port block.
// Assumes: Pin levels settle through the synchroniser within five cycles.
// Notes:   Port C keeps its latch from the port loop for the control test.
`timescale 1ns/100ps
`default_nettype none
module gzb_ports_tb;
  import gzb_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic       ref_clk;
  logic       reset_n;
  logic       reg_wr;
  logic       reg_rd;
  logic       hw_stop;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] rdata;
  logic [7:0] ctl_out;
  logic [7:0] ctl_oe;
  logic [7:0] ctl_in;
  logic       irq1_bias_en;
  logic       irq2_bias_en;
  logic [7:0] pin_in [3];
  logic [7:0] pin_out [3];
  logic [7:0] pin_oe [3];
  logic [7:0] board [3];
  int         miscompares;
  int         tests_run;
  localparam logic [7:0] DOFF [3] = '{GZB_OFF_PORT_A_DATA, GZB_OFF_PORT_B_DATA,
                                      GZB_OFF_PORT_C_DATA};
  localparam logic [7:0] DIROF [3] = '{GZB_OFF_PORT_A_DIR, GZB_OFF_PORT_B_DIR,
                                       GZB_OFF_PORT_C_DIR};
  // ****************************************************************
  // Design and board
  // ****************************************************************
  gzb_ports i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .hw_stop(hw_stop),
    .port_a_pins_in(pin_in[0]), .port_a_pins_out(pin_out[0]), .port_a_pins_oe(pin_oe[0]),
    .port_b_pins_in(pin_in[1]), .port_b_pins_out(pin_out[1]), .port_b_pins_oe(pin_oe[1]),
    .port_c_pins_in(pin_in[2]), .port_c_pins_out(pin_out[2]), .port_c_pins_oe(pin_oe[2]),
    .ctl_out(ctl_out), .ctl_oe(ctl_oe), .ctl_in(ctl_in),
    .irq1_bias_en(irq1_bias_en), .irq2_bias_en(irq2_bias_en));
  // One board model per port resolves each pin's level.
  for (genvar g = 0; g < 3; g++) begin : g_pin
    gzb_pin_model i_pin (.pins_out(pin_out[g]), .pins_oe(pin_oe[g]),
                         .board_lvl(board[g]), .pins_in(pin_in[g]));
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Counts a comparison and reports a difference at once.
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Lets n edges pass and steps clear of the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle read strobe; data stand only in the following cycle.
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rdata = reg_rdata;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk(what, rdata, exp);
  endtask
  task automatic complete_run;
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // Clock, watchdog and tests
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // The tests need well under a thousand cycles.
  initial begin
    #(40 * 5000);
    miscompares++;
    complete_run();
  end
  initial begin
    miscompares = 0;
    tests_run = 0;
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    hw_stop = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    ctl_out = 8'h10;
    ctl_oe = 8'h10;
    board = '{8'h3C, 8'h3C, 8'h3C};
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    tick(1);
    rdchk("zcm", GZB_OFF_ZERO_CROSS, 8'h06);
    chk("bias", {6'h00, irq2_bias_en, irq1_bias_en}, 8'h01);
    rdchk("fsel", GZB_OFF_PORT_C_FSEL, 8'h00);
    for (int p = 0; p < 3; p++) begin
      chk("oe_rst", pin_oe[p], 8'h00);
      rdchk("dir_rst", DIROF[p], 8'hFF);
    end
    // Each port: latch first, then low nibble in, high nibble out.
    for (int p = 0; p < 3; p++) begin
      wr(DOFF[p], 8'hA5);
      wr(DIROF[p], 8'h0F);
      tick(5);
      chk("oe", pin_oe[p], 8'hF0);
      chk("out", pin_out[p] & 8'hF0, 8'hA0);
      rdchk("view", DOFF[p], 8'hAC);
      wr(GZB_OFF_BIT_OP, {GZB_OP_CLEAR, 2'(p), 4'h2});
      wr(DIROF[p], 8'h00);
      tick(1);
      chk("rmw", pin_out[p], 8'hA8);
      wr(GZB_OFF_BIT_OP, {GZB_OP_SET, 2'(p), 4'h0});
      tick(1);
      chk("set", pin_out[p], 8'hA9);
      wr(GZB_OFF_BIT_OP, {GZB_OP_TEST, 2'(p), 4'h7});
      rd(GZB_OFF_BIT_OP);
      chk("test", rdata & 8'h01, 8'h01);
      wr(GZB_OFF_BIT_OP, {GZB_OP_TEST, 2'(p), 4'h2});
      rd(GZB_OFF_BIT_OP);
      chk("test_zero", rdata, 8'h00);
    end
    // Timer output and interrupt-2 input handed to peripherals.
    wr(GZB_OFF_PORT_C_FSEL, 8'h18);
    tick(5);
    chk("oe_c", pin_oe[2], 8'hF7);
    chk("out_c", pin_out[2], 8'hB1);
    rdchk("view_c", GZB_OFF_PORT_C_DATA, 8'hB9);
    chk("ctl_in", ctl_in & 8'h08, 8'h08);
    chk("bias", {6'h00, irq2_bias_en, irq1_bias_en}, 8'h03);
    wr(GZB_OFF_ZERO_CROSS, 8'h00);
    tick(1);
    chk("bias", {6'h00, irq2_bias_en, irq1_bias_en}, 8'h00);
    wr(GZB_OFF_ZERO_CROSS, 8'hFF);
    rdchk("zcm", GZB_OFF_ZERO_CROSS, 8'h06);
    // Hardware STOP forces direction and select defaults and refuses a port A direction write.
    @(posedge ref_clk);
    hw_stop <= 1'b1;
    tick(1);
    chk("bias", {6'h00, irq2_bias_en, irq1_bias_en}, 8'h00);
    for (int p = 0; p < 3; p++) begin
      chk("oe_stop", pin_oe[p], 8'h00);
    end
    wr(GZB_OFF_PORT_A_DIR, 8'h00);
    rdchk("dir_stop", GZB_OFF_PORT_A_DIR, 8'hFF);
    rdchk("fsel", GZB_OFF_PORT_C_FSEL, 8'h00);
    @(posedge ref_clk);
    hw_stop <= 1'b0;
    tick(1);
    chk("bias", {6'h00, irq2_bias_en, irq1_bias_en}, 8'h01);
    rdchk("unmapped", 8'h30, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
